//--- cehn_defines.svh
// Named constants of the card-emulation host-notify block.
// Assumes a 100 MHz core clock; included by the top and the bench.
`ifndef CEHN_DEFINES_SVH
`define CEHN_DEFINES_SVH

`define CEHN_CLK_NS 10
`define CEHN_WAKE_NS 2000
`define CEHN_PREP_NS 500
`define CEHN_WAKE_CYC 12'((`CEHN_WAKE_NS + `CEHN_CLK_NS - 1) / `CEHN_CLK_NS)
`define CEHN_PREP_CYC 12'((`CEHN_PREP_NS + `CEHN_CLK_NS - 1) / `CEHN_CLK_NS)
`define CEHN_CNT_ONE 12'h001
`define CEHN_CNT_ZERO 12'h000

`define CEHN_I2C_ADDR 7'h24
`define CEHN_LAST_BIT 4'h8
`define CEHN_BYTE_MAX 2'h3
`define CEHN_IDX_LAST 2'h3
`define CEHN_TX_IDLE 8'hFF
`define CEHN_PIN_IDLE 4'hE

`define CEHN_CMD_CONFIG 8'h14
`define CEHN_CFG_CARD 8'h02
`define CEHN_CFG_IRQ 8'h00
`define CEHN_CMD_FWVER 8'h02
`define CEHN_RSP_INC 8'h01
`define CEHN_ACK_B0 8'h00
`define CEHN_ACK_B1 8'hFF
// Arbitrary firmware version value.
`define CEHN_FW_VER 8'h11
`define CEHN_EVT_CODE 8'hE0
`define CEHN_RSP_NONE 8'h00

`endif

//--- cehn_host.sv
// Host controller model: an I2C master that honours clock stretching.
// Assumes the bench resolves open-drain SCL and SDA with pull-ups.
`timescale 1ns/10ps
// ==========
// Host master
module cehn_host (
    input wire logic hclk,
    input wire logic scl,
    input wire logic sda,
    output logic scl_lo,
    output logic sda_lo
);
    int stretch = 0;
    int stall_err = 0;
    initial begin
        scl_lo = 1'b0;
        sda_lo = 1'b0;
    end
    task automatic hc(input int n);
        repeat (n) @(posedge hclk);
    endtask : hc
    // One SCL period, waiting while the device holds SCL low.
    task automatic bit_io(input logic b, output logic r);
        int i;
        sda_lo <= !b;
        hc(4);
        scl_lo <= 1'b0;
        hc(1);
        for (i = 0; i < 100 && scl !== 1'b1; i++) hc(1);
        if (i == 100) stall_err++;
        stretch += i;
        hc(4);
        r = sda;
        hc(4);
        scl_lo <= 1'b1;
        hc(4);
    endtask : bit_io
    task automatic start();
        stretch = 0;
        sda_lo <= 1'b1;
        hc(4);
        scl_lo <= 1'b1;
        hc(4);
    endtask : start
    task automatic stop();
        sda_lo <= 1'b1;
        hc(4);
        scl_lo <= 1'b0;
        hc(4);
        sda_lo <= 1'b0;
        hc(8);
    endtask : stop
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int k = 7; k >= 0; k--) bit_io(d[k], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask : wr_byte
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int k = 7; k >= 0; k--) begin
            bit_io(1'b1, r);
            d[k] = r;
        end
        bit_io(last, r);
    endtask : rd_byte
endmodule : cehn_host

//--- cehn_pkg.sv
// Types of the card-emulation host-notify block.
// Assumes cehn_defines.svh is on the include path.
package cehn_pkg;

    typedef enum logic [1:0] {
        PW_SLEEP = 2'h0,
        PW_WAKE = 2'h1,
        PW_RUN = 2'h3
    } cehn_pw_t;

    typedef struct packed {
        logic scl;
        logic sda;
        logic hreq_n;
        logic tgl;
    } cehn_pins_t;

    typedef struct packed {
        logic [7:0] sh;
        logic tgl;
    } cehn_link_t;

    typedef struct packed {
        cehn_pw_t pw;
        logic [11:0] wake_cnt;
        logic [11:0] prep_cnt;
        logic scl_q;
        logic sda_q;
        logic tgl_q;
        logic in_frame;
        logic addr_ph;
        logic sel;
        logic rd;
        logic ack_due;
        logic [3:0] bit_cnt;
        logic [1:0] nbyte;
        logic [7:0] cmd0;
        logic [7:0] cmd1;
        logic [7:0] cmd2;
        logic [1:0] tx_idx;
        logic [7:0] tx_byte;
        logic [7:0] rsp_code;
        logic [7:0] rsp_data;
        logic rsp_rdy;
        logic evt;
        logic card_mode;
        logic irq_en;
        logic sda_oe;
        logic scl_oe;
        logic irq_n;
    } cehn_state_t;

endpackage : cehn_pkg

//--- cehn_sync.sv
// Two-flop synchroniser for a group of levels.
// Assumes the destination clock and an active-low async reset.
`timescale 1ns/10ps
module cehn_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : cehn_sync

//--- cehn_top.sv
// I2C host port of a contactless transceiver: wake on command with clock
// stretching, response readout and interrupt notification to the host.
// Assumes scl_clk and scl_i are the same bus wire; pins are open drain.
`timescale 1ns/10ps
`include "cehn_defines.svh"

// Contract
// - A command arriving during sleep holds SCL low until wake-up ends.
// - The interrupt goes active once acknowledge and answer are readable.
// - Once a CONFIG command sets card mode the device stays in it and serves later commands.
// - A finished contactless transaction raises the interrupt.
module cehn_top
    import cehn_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic scl_clk,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic hreq_n,
    input wire logic rf_done,
    output logic irq_n
);
    logic rst_sync_n;
    cehn_pins_t pin_raw;
    cehn_pins_t pin_s;
    cehn_link_t lk_r;
    cehn_link_t lk_nxt;
    cehn_state_t st_r;
    cehn_state_t st_nxt;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic rd_stop;
    logic wr_stop;

    // =====================================================================
    // Reset release and pin synchronisers
    cehn_sync #(.W(1)) u_rst (
        .clock(clock),
        .rst_n(rst_n),
        .d(1'b1),
        .q(rst_sync_n)
    );

    assign pin_raw = '{scl: scl_i, sda: sda_i, hreq_n: hreq_n,
                       tgl: lk_r.tgl};

    // Pins reset to their idle level, so no false edge or wake request
    // follows the release of reset.
    cehn_sync #(.W(4), .RST_VAL(`CEHN_PIN_IDLE)) u_pins (
        .clock(clock),
        .rst_n(rst_sync_n),
        .d(pin_raw),
        .q(pin_s)
    );

    // =====================================================================
    // Link domain: SDA is source-synchronous to SCL, so each rising edge
    // shifts it in and flips a toggle; the shift register then holds still
    // until the next edge, long after the core has seen the toggle.
    always_comb begin
        lk_nxt = lk_r;
        lk_nxt.sh = {lk_r.sh[6:0], sda_i};
        lk_nxt.tgl = ~lk_r.tgl;
    end

    always_ff @(posedge scl_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            lk_r <= '0;
        end else begin
            lk_r <= lk_nxt;
        end
    end

    // =====================================================================
    // Core domain
    assign rise = pin_s.tgl != st_r.tgl_q;
    assign fall = st_r.scl_q & ~pin_s.scl;
    assign start = pin_s.scl & st_r.sda_q & ~pin_s.sda;
    assign stop = pin_s.scl & ~st_r.sda_q & pin_s.sda;
    assign rd_stop = stop & st_r.sel & st_r.rd;
    assign wr_stop = stop & st_r.sel & ~st_r.rd & (st_r.nbyte != 2'h0);

    function automatic logic [7:0] tx_rom(input logic [1:0] i,
                                          input cehn_state_t s);
        logic [7:0] b;
        b = `CEHN_ACK_B0;
        case (i)
            2'h0: b = `CEHN_ACK_B0;
            2'h1: b = `CEHN_ACK_B1;
            2'h2: b = s.rsp_rdy ? s.rsp_code : `CEHN_EVT_CODE;
            2'h3: b = s.rsp_rdy ? s.rsp_data : `CEHN_RSP_NONE;
            default: b = `CEHN_ACK_B0;
        endcase
        return b;
    endfunction : tx_rom

    always_comb begin
        st_nxt = st_r;
        st_nxt.scl_q = pin_s.scl;
        st_nxt.sda_q = pin_s.sda;
        st_nxt.tgl_q = pin_s.tgl;

        if (rise && st_r.in_frame) begin
            if (st_r.bit_cnt == `CEHN_LAST_BIT) begin
                st_nxt.bit_cnt = 4'h0;
                if (st_r.sel && st_r.rd) begin
                    // A master NACK ends the read: SDA stays free for STOP.
                    st_nxt.tx_idx = st_r.tx_idx + 2'h1;
                    st_nxt.tx_byte = lk_r.sh[0] ? `CEHN_TX_IDLE :
                        tx_rom(st_r.tx_idx + 2'h1, st_r);
                end
            end else begin
                st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
            end
            if (st_r.bit_cnt == `CEHN_LAST_BIT - 4'h1) begin
                st_nxt.ack_due = 1'b0;
                if (st_r.addr_ph) begin
                    st_nxt.addr_ph = 1'b0;
                    if (lk_r.sh[7:1] == `CEHN_I2C_ADDR) begin
                        st_nxt.sel = 1'b1;
                        st_nxt.rd = lk_r.sh[0];
                        st_nxt.ack_due = 1'b1;
                        // The address ack clock steps the index to byte 0.
                        st_nxt.tx_idx = `CEHN_IDX_LAST;
                    end
                end else if (st_r.sel && !st_r.rd) begin
                    st_nxt.ack_due = 1'b1;
                    case (st_r.nbyte)
                        2'h0: st_nxt.cmd0 = lk_r.sh;
                        2'h1: st_nxt.cmd1 = lk_r.sh;
                        2'h2: st_nxt.cmd2 = lk_r.sh;
                        default: st_nxt.cmd2 = st_r.cmd2;
                    endcase
                    if (st_r.nbyte != `CEHN_BYTE_MAX) begin
                        st_nxt.nbyte = st_r.nbyte + 2'h1;
                    end
                end
            end
        end

        if (fall && st_r.in_frame) begin
            if (st_r.bit_cnt == `CEHN_LAST_BIT) begin
                st_nxt.sda_oe = st_r.ack_due;
            end else begin
                st_nxt.sda_oe = st_r.sel & st_r.rd &
                    ~st_r.tx_byte[3'(4'h7 - st_r.bit_cnt)];
            end
            // The ack slot has ended; a write to a device not yet in PW_RUN stalls here.
            if (st_r.bit_cnt == 4'h0 && st_r.sel && !st_r.rd &&
                st_r.pw != PW_RUN) begin
                st_nxt.scl_oe = 1'b1;
                if (st_r.pw == PW_SLEEP) begin
                    st_nxt.pw = PW_WAKE;
                    st_nxt.wake_cnt = `CEHN_WAKE_CYC;
                end
            end
        end

        if (start) begin
            st_nxt.in_frame = 1'b1;
            st_nxt.addr_ph = 1'b1;
            st_nxt.bit_cnt = 4'h0;
            st_nxt.sel = 1'b0;
            st_nxt.rd = 1'b0;
            st_nxt.nbyte = 2'h0;
            st_nxt.ack_due = 1'b0;
            st_nxt.sda_oe = 1'b0;
        end

        if (stop) begin
            st_nxt.in_frame = 1'b0;
            st_nxt.sel = 1'b0;
            st_nxt.sda_oe = 1'b0;
        end

        // Host wake request is optional; it only starts wake-up early.
        if (!pin_s.hreq_n && st_r.pw == PW_SLEEP) begin
            st_nxt.pw = PW_WAKE;
            st_nxt.wake_cnt = `CEHN_WAKE_CYC;
        end

        if (st_r.pw == PW_WAKE) begin
            st_nxt.wake_cnt = st_r.wake_cnt - `CEHN_CNT_ONE;
            if (st_r.wake_cnt == `CEHN_CNT_ONE) begin
                st_nxt.pw = PW_RUN;
                st_nxt.scl_oe = 1'b0;
            end
        end

        if (wr_stop) begin
            st_nxt.rsp_code = st_r.cmd0 + `CEHN_RSP_INC;
            st_nxt.rsp_data = `CEHN_RSP_NONE;
            if (st_r.cmd0 == `CEHN_CMD_CONFIG &&
                st_r.cmd1 == `CEHN_CFG_CARD &&
                st_r.cmd2 == `CEHN_CFG_IRQ) begin
                st_nxt.card_mode = 1'b1;
                st_nxt.irq_en = 1'b1;
            end
            if (st_r.cmd0 == `CEHN_CMD_FWVER) begin
                st_nxt.rsp_data = `CEHN_FW_VER;
            end
            st_nxt.rsp_rdy = 1'b0;
            st_nxt.prep_cnt = `CEHN_PREP_CYC;
        end

        if (rd_stop) begin
            st_nxt.rsp_rdy = 1'b0;
            st_nxt.evt = 1'b0;
        end

        // Setting events come last so they win over a same-cycle clear.
        if (st_r.prep_cnt != `CEHN_CNT_ZERO) begin
            st_nxt.prep_cnt = st_r.prep_cnt - `CEHN_CNT_ONE;
            if (st_r.prep_cnt == `CEHN_CNT_ONE) begin
                st_nxt.rsp_rdy = 1'b1;
            end
        end
        if (rf_done && st_r.card_mode && st_r.irq_en) begin
            st_nxt.evt = 1'b1;
        end

        st_nxt.irq_n = ~(st_nxt.rsp_rdy | st_nxt.evt);
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st_r <= '{pw: PW_SLEEP, scl_q: 1'b1, sda_q: 1'b1, irq_n: 1'b1,
                      default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe = st_r.scl_oe;
    assign sda_oe = st_r.sda_oe;
    assign irq_n = st_r.irq_n;

    // =====================================================================
    // Checks
    a_stretch_holds: assert property (@(posedge clock) disable iff (!rst_sync_n)
        (st_r.scl_oe && st_r.pw == PW_WAKE && st_r.wake_cnt > `CEHN_CNT_ONE)
            |=> st_r.scl_oe)
        else $error("SCL released before wake-up finished");

    a_stretch_end: assert property (@(posedge clock) disable iff (!rst_sync_n)
        $fell(st_r.scl_oe) |-> ($past(st_r.pw) == PW_WAKE && st_r.pw == PW_RUN))
        else $error("SCL released without wake-up completing");

    a_irq_ready: assert property (@(posedge clock) disable iff (!rst_sync_n)
        $rose(st_r.rsp_rdy) |->
            (!irq_n && $past(st_r.prep_cnt) == `CEHN_CNT_ONE))
        else $error("Interrupt not raised when response became ready");

    a_card_kept: assert property (@(posedge clock) disable iff (!rst_sync_n)
        st_r.card_mode |=> st_r.card_mode ##1 st_r.card_mode)
        else $error("Card emulation mode lost");

    a_event_irq: assert property (@(posedge clock) disable iff (!rst_sync_n)
        (rf_done && st_r.card_mode && st_r.irq_en) |=> (!irq_n && st_r.evt))
        else $error("Transaction event did not raise interrupt");

    a_irq_release: assert property (@(posedge clock) disable iff (!rst_sync_n)
        $rose(irq_n) |-> $past(rd_stop))
        else $error("Interrupt dropped without a host read");

endmodule : cehn_top

//--- tb_top.sv
// Self-checking bench for cehn_top driven by the host master model.
// Assumes open-drain SCL and SDA with pull-ups and an 80 ns host clock.
`timescale 1ns/10ps
`include "cehn_defines.svh"
// ==========
// Bench
module tb_top;
    logic clock = 1'b0;
    logic hclk = 1'b0;
    logic rst_n = 1'b0;
    logic hreq_n = 1'b1;
    logic rf_done = 1'b0;
    logic scl_o, scl_oe, sda_o, sda_oe, irq_n, scl_lo, sda_lo;
    wire logic scl = !(scl_oe || scl_lo);
    wire logic sda = !(sda_oe || sda_lo);
    int error_cnt = 0;
    int tests_run = 0;
    initial forever #5 clock = ~clock;
    initial begin
        #3;
        forever #40 hclk = ~hclk;
    end
    cehn_top u_dut (.clock(clock), .rst_n(rst_n), .scl_clk(scl),
        .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .hreq_n(hreq_n),
        .rf_done(rf_done), .irq_n(irq_n));
    cehn_host u_host (.hclk(hclk), .scl(scl), .sda(sda), .scl_lo(scl_lo),
        .sda_lo(sda_lo));
    task automatic chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask : chk
    task automatic complete_run();
        chk(u_host.stall_err == 0, "bus stall limit");
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    task automatic wait_irq(input logic lvl, input int n);
        int i;
        for (i = 0; i < n && irq_n !== lvl; i++) begin
            @(posedge clock);
            #1;
        end
        chk(irq_n === lvl, "interrupt level");
        if (irq_n !== lvl) complete_run();
    endtask : wait_irq
    task automatic send(input logic [23:0] c, input int n);
        logic a;
        u_host.start();
        u_host.wr_byte({`CEHN_I2C_ADDR, 1'b0}, a);
        chk(a, "address ack");
        for (int k = 0; k < n; k++) begin
            u_host.wr_byte(c[23-8*k -: 8], a);
            chk(a, "command ack");
        end
        chk(irq_n === 1'b1, "early interrupt");
        u_host.stop();
    endtask : send
    task automatic fetch(input logic [7:0] code, input logic [7:0] data);
        logic a;
        logic [31:0] exp;
        logic [7:0] d;
        exp = {`CEHN_ACK_B0, `CEHN_ACK_B1, code, data};
        u_host.start();
        u_host.wr_byte({`CEHN_I2C_ADDR, 1'b1}, a);
        chk(a, "read address ack");
        for (int k = 0; k < 4; k++) begin
            u_host.rd_byte(k == 3, d);
            chk(d === exp[31-8*k -: 8], "response byte");
        end
        chk(irq_n === 1'b0, "interrupt held");
        u_host.stop();
        wait_irq(1'b1, 20);
    endtask : fetch
    // ==========
    // Scenarios
    task automatic t_config();
        send({`CEHN_CMD_CONFIG, `CEHN_CFG_CARD, `CEHN_CFG_IRQ}, 3);
        // The host waits 9 of its 80 ns clocks before it first looks at SCL.
        chk(u_host.stretch >= `CEHN_WAKE_NS / 80 - 9 &&
            u_host.stretch <= `CEHN_WAKE_NS / 80 + 1, "stretch");
        wait_irq(1'b0, 200);
        fetch(`CEHN_CMD_CONFIG + `CEHN_RSP_INC, `CEHN_RSP_NONE);
    endtask : t_config
    task automatic t_query(input logic use_req);
        if (use_req) begin
            @(posedge clock);
            hreq_n <= 1'b0;
            repeat (4) @(posedge clock);
            hreq_n <= 1'b1;
        end
        send({`CEHN_CMD_FWVER, 16'h0000}, 1);
        chk(u_host.stretch == 0, "stretch when awake");
        wait_irq(1'b0, 200);
        fetch(`CEHN_CMD_FWVER + `CEHN_RSP_INC, `CEHN_FW_VER);
    endtask : t_query
    task automatic t_rf();
        @(posedge clock);
        rf_done <= 1'b1;
        @(posedge clock);
        rf_done <= 1'b0;
        #1;
        chk(irq_n === 1'b0, "transaction interrupt");
        fetch(`CEHN_EVT_CODE, `CEHN_RSP_NONE);
    endtask : t_rf
    task automatic t_wake();
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        repeat (6) @(posedge clock);
        chk(irq_n === 1'b1 && scl_oe === 1'b0, "reset mid-run");
        hreq_n <= 1'b0;
        repeat (4) @(posedge clock);
        hreq_n <= 1'b1;
        repeat (`CEHN_WAKE_CYC + 20) @(posedge clock);
        send({`CEHN_CMD_CONFIG, `CEHN_CFG_CARD, `CEHN_CFG_IRQ}, 3);
        chk(u_host.stretch == 0, "stretch after wake request");
        wait_irq(1'b0, 200);
        fetch(`CEHN_CMD_CONFIG + `CEHN_RSP_INC, `CEHN_RSP_NONE);
    endtask : t_wake
    initial begin
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        repeat (6) @(posedge clock);
        chk(irq_n === 1'b1 && scl_oe === 1'b0 && sda_oe === 1'b0 &&
            scl_o === 1'b0 && sda_o === 1'b0, "reset");
        t_config();
        t_query(1'b1);
        t_query(1'b0);
        t_rf();
        t_wake();
        complete_run();
    end
endmodule : tb_top
